// ---- dpb_array.sv ----
// Storage array holding one two-word pair per address.
`timescale 1ns/10ps
`default_nettype none
module dpb_array #(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 18
) (
   // Clock.
   input wire logic clk_i,
   // Write side.
   input wire logic wr_en_i,
   input wire logic [ADDR_W-1:0] wr_addr_i,
   input wire logic [2*DATA_W-1:0] wr_pair_i,
   // Read side.
   input wire logic [ADDR_W-1:0] rd_addr_i,
   output logic [2*DATA_W-1:0] rd_pair_o
);
   logic [2*DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

   // Reads are combinational so the emission edge sees the freshest pair.
   assign rd_pair_o = mem[rd_addr_i];

   // Array write, no reset: contents are undefined until written.
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_pair_i;
      end
   end
endmodule // dpb_array
`default_nettype wire

// ---- dpb_ctl_model.sv ----
// Controller model driving clock pairs, shared address, port selects and write words.
`timescale 1ns/10ps
`default_nettype none
module dpb_ctl_model
   import dpb_pkg::*;
(
   // Clock, reset and bench requests.
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic rd_go_i,
   input wire logic wr_go_i,
   input wire logic [dpb_pkg::DPB_ADDR_W-1:0] ra_i,
   input wire logic [dpb_pkg::DPB_ADDR_W-1:0] wa_i,
   input wire logic [2*dpb_pkg::DPB_DATA_W-1:0] wp_i,
   // Phase count for the bench, then pins toward the memory.
   output logic [2:0] ph_o,
   output logic k_o,
   output logic k_n_o,
   output logic c_o,
   output logic c_n_o,
   output logic [dpb_pkg::DPB_ADDR_W-1:0] addr_o,
   output logic rd_sel_n_o,
   output logic wr_sel_n_o,
   output logic [dpb_pkg::DPB_DATA_W-1:0] wd_o
);
   logic [DPB_ADDR_W-1:0] wa_r;
   logic [DPB_DATA_W-1:0] w1_r;
   // Eight clocks per K period, so every pin moves two clocks clear of the edge that samples it.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ph_o <= 3'h0;
         {k_o, k_n_o, c_o, c_n_o} <= 4'h0;
         {rd_sel_n_o, wr_sel_n_o} <= 2'h3;
      end else begin
         ph_o <= ph_o + 3'h1;
         case (ph_o)
            3'h0: {k_o, k_n_o} <= 2'h2;
            3'h4: {k_o, k_n_o} <= 2'h1;
            3'h2: begin
               {c_o, c_n_o} <= 2'h2;
               {rd_sel_n_o, wr_sel_n_o} <= 2'h3;
               addr_o <= wa_r;
               wd_o <= w1_r;
            end
            3'h6: begin
               {c_o, c_n_o} <= 2'h1;
               {rd_sel_n_o, wr_sel_n_o} <= {~rd_go_i, ~wr_go_i};
               addr_o <= ra_i;
               wd_o <= wp_i[DPB_DATA_W-1:0];
               wa_r <= wa_i;
               w1_r <= wp_i[2*DPB_DATA_W-1:DPB_DATA_W];
            end
            default: ;
         endcase
      end
   end
endmodule // dpb_ctl_model
`default_nettype wire

// ---- dpb_mem.sv ----
// Dual-port double-rate burst memory core sampled in the system clock domain.
`timescale 1ns/10ps
`default_nettype none
module dpb_mem
#(
   parameter int ADDR_W = dpb_pkg::DPB_ADDR_W,
   parameter int DATA_W = dpb_pkg::DPB_DATA_W
) (
   // System clock and reset.
   input wire logic clk_i,
   input wire logic rstn_i,
   // Clock pins from the controller.
   input wire logic link_k_i,
   input wire logic link_k_n_i,
   input wire logic out_c_i,
   input wire logic out_c_n_i,
   // Mode pins.
   input wire logic single_clk_i,
   input wire logic pll_disable_i,
   // Address and port selects.
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic rd_sel_n_i,
   input wire logic wr_sel_n_i,
   // Write data port.
   input wire logic [DATA_W-1:0] wr_data_i,
   // Read data port and echo clocks.
   output logic [DATA_W-1:0] rd_data_o,
   output logic returned_timing_strobe_o,
   output logic returned_timing_strobe_n_o
);
   import dpb_pkg::*;

   localparam int SW = DPB_CTRL_PINS + ADDR_W + DATA_W;

   logic [SW-1:0] pin_vec;
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   logic [3:0] clk_hist_r;
   logic k_s, k_n_s, c_s, c_n_s, single_s, pll_s, rsel_n_s, wsel_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] wdata_s;
   logic k_rise, k_n_rise, o_rise, o_n_rise, o_edge, rd_take, wr_take;
   logic rd_pend_r, rd_place;
   logic [ADDR_W-1:0] rd_pend_a_r, rd_addr_pick;
   dpb_wr_state_t wr_st_r, wr_st_nxt;
   logic [DATA_W-1:0] wbuf0_r, wbuf1_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [DPB_RD_SLOTS-1:0] slot_v_r, slot_v_nxt, slot_w_r, slot_w_nxt;
   logic [ADDR_W-1:0] slot_a_r [DPB_RD_SLOTS];
   logic [ADDR_W-1:0] slot_a_nxt [DPB_RD_SLOTS];
   logic [2*DATA_W-1:0] arr_pair, emit_pair;
   logic bypass_hit;
   logic [DATA_W-1:0] rd_data_r;
   logic strobe_r, strobe_n_r;

   // Picks the first or second word of a stored pair.
   function automatic logic [DATA_W-1:0] pick_word(input logic [2*DATA_W-1:0] pair, input logic second);
      pick_word = second ? pair[2*DATA_W-1:DATA_W] : pair[DATA_W-1:0];
   endfunction

   assign pin_vec = {link_k_i, link_k_n_i, out_c_i, out_c_n_i, single_clk_i, pll_disable_i,
                     rd_sel_n_i, wr_sel_n_i, addr_i, wr_data_i};
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sync1_r <= '0;
         sync2_r <= '0;
         clk_hist_r <= '0;
      end else begin
         sync1_r <= pin_vec;
         sync2_r <= sync1_r;
         clk_hist_r <= sync2_r[SW-1:SW-4];
      end
   end

   // Named views of the synchronised pins.
   assign {k_s, k_n_s, c_s, c_n_s, single_s, pll_s, rsel_n_s, wsel_n_s} = sync2_r[SW-1:SW-DPB_CTRL_PINS];
   assign addr_s = sync2_r[ADDR_W+DATA_W-1:DATA_W];
   assign wdata_s = sync2_r[DATA_W-1:0];

   assign k_rise = k_s & ~clk_hist_r[3];
   assign k_n_rise = k_n_s & ~clk_hist_r[2];
   assign o_rise = single_s ? k_rise : (c_s & ~clk_hist_r[1]);
   assign o_n_rise = single_s ? k_n_rise : (c_n_s & ~clk_hist_r[0]);
   assign o_edge = o_rise | o_n_rise;
   assign rd_take = k_rise & ~rsel_n_s;
   assign wr_take = k_rise & ~wsel_n_s;

   // A read is scheduled at the output rise that belongs to its K rise, so latency
   // is counted in output clock cycles even when the C pair lags K.
   assign rd_place = o_rise & (rd_take | rd_pend_r);
   assign rd_addr_pick = rd_take ? addr_s : rd_pend_a_r;

   // hold a read until its matching output rise
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rd_pend_r <= 1'b0;
         rd_pend_a_r <= '0;
      end else if (rd_take && !o_rise) begin
         rd_pend_r <= 1'b1;
         rd_pend_a_r <= addr_s;
      end else if (o_rise) begin
         rd_pend_r <= 1'b0;
      end
   end

   always_comb begin
      wr_st_nxt = wr_st_r;
      case (wr_st_r)
         DPB_WR_IDLE: begin
            if (wr_take) begin
               wr_st_nxt = DPB_WR_HALF;
            end
         end
         DPB_WR_HALF: begin
            if (k_n_rise) begin
               wr_st_nxt = DPB_WR_COMMIT;
            end
         end
         DPB_WR_COMMIT: begin
            wr_st_nxt = wr_take ? DPB_WR_HALF : DPB_WR_IDLE;
         end
         default: begin
            wr_st_nxt = DPB_WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         wr_st_r <= DPB_WR_IDLE;
         wbuf0_r <= '0;
         wbuf1_r <= '0;
         waddr_r <= '0;
      end else begin
         wr_st_r <= wr_st_nxt;
         if (wr_take && wr_st_r != DPB_WR_HALF) begin
            wbuf0_r <= wdata_s;
         end
         if (wr_st_r == DPB_WR_HALF && k_n_rise) begin
            wbuf1_r <= wdata_s;
            waddr_r <= addr_s;
         end
      end
   end

   dpb_array #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W)
   ) u_array (
      .clk_i(clk_i),
      .wr_en_i(wr_st_r == DPB_WR_COMMIT),
      .wr_addr_i(waddr_r),
      .wr_pair_i({wbuf1_r, wbuf0_r}),
      .rd_addr_i(slot_a_r[0]),
      .rd_pair_o(arr_pair)
   );

   // Read schedule: slots shift one place per output edge, then a new read
   // is placed by latency. Four slots suffice since a burst ends within two cycles.
   always_comb begin
      slot_v_nxt = slot_v_r;
      slot_w_nxt = slot_w_r;
      slot_a_nxt = slot_a_r;
      if (o_edge) begin
         for (int i = 0; i < DPB_RD_SLOTS-1; i++) begin
            slot_v_nxt[i] = slot_v_r[i+1];
            slot_w_nxt[i] = slot_w_r[i+1];
            slot_a_nxt[i] = slot_a_r[i+1];
         end
         slot_v_nxt[DPB_RD_SLOTS-1] = 1'b0;
         slot_w_nxt[DPB_RD_SLOTS-1] = 1'b0;
         slot_a_nxt[DPB_RD_SLOTS-1] = '0;
      end
      if (rd_place) begin
         for (int i = 0; i < DPB_RD_SLOTS; i++) begin
            if (i == (pll_s ? DPB_LAT_HALF_IDX : DPB_LAT_ONE_IDX) ||
                i == (pll_s ? DPB_LAT_HALF_IDX + 1 : DPB_LAT_ONE_IDX + 1)) begin
               slot_v_nxt[i] = 1'b1;
               slot_w_nxt[i] = (i != (pll_s ? DPB_LAT_HALF_IDX : DPB_LAT_ONE_IDX));
               slot_a_nxt[i] = rd_addr_pick;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         slot_v_r <= '0;
         slot_w_r <= '0;
         for (int i = 0; i < DPB_RD_SLOTS; i++) begin
            slot_a_r[i] <= '0;
         end
      end else begin
         slot_v_r <= slot_v_nxt;
         slot_w_r <= slot_w_nxt;
         slot_a_r <= slot_a_nxt;
      end
   end

   // forward a write not yet in the array
   assign bypass_hit = (wr_st_r == DPB_WR_COMMIT) && (waddr_r == slot_a_r[0]);
   assign emit_pair = bypass_hit ? {wbuf1_r, wbuf0_r} : arr_pair;

   // launch on output edges; idle edges hold the last word.
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         rd_data_r <= '0;
      end else if (o_edge && slot_v_r[0]) begin
         rd_data_r <= pick_word(emit_pair, slot_w_r[0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         strobe_r <= 1'b0;
         strobe_n_r <= 1'b1;
      end else if (o_rise) begin
         strobe_r <= 1'b1;
         strobe_n_r <= 1'b0;
      end else if (o_n_rise) begin
         strobe_r <= 1'b0;
         strobe_n_r <= 1'b1;
      end
   end

   assign rd_data_o = rd_data_r;
   assign returned_timing_strobe_o = strobe_r;
   assign returned_timing_strobe_n_o = strobe_n_r;

   // Checks on the design's own behaviour.
   default clocking dpb_cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   slow_latency_a: assert property (rd_place && pll_s |=> slot_v_r[2] && slot_v_r[3] && !slot_w_r[2] && slot_w_r[3])
      else $error("read not scheduled at one and half cycles");
   fast_latency_a: assert property (rd_place && !pll_s |=> slot_v_r[1] && slot_v_r[2] && !slot_w_r[1] && slot_w_r[2])
      else $error("read not scheduled at one cycle");
   read_addr_a: assert property (rd_place |=> slot_a_r[pll_s ? 3 : 2] == $past(rd_addr_pick))
      else $error("read address not latched");
   read_idle_a: assert property (k_rise && rsel_n_s && !rd_pend_r |-> !rd_place)
      else $error("deselected read port acted");
   write_idle_a: assert property (wr_st_r == DPB_WR_IDLE && !wr_take |=> wr_st_r == DPB_WR_IDLE)
      else $error("deselected write port acted");
   write_commit_a: assert property (wr_st_r == DPB_WR_HALF && k_n_rise |=> wr_st_r == DPB_WR_COMMIT ##1 wr_st_r != DPB_WR_COMMIT)
      else $error("write commit not one cycle");
   coherent_read_a: assert property (o_edge && slot_v_r[0] && bypass_hit |=> rd_data_r == ($past(slot_w_r[0]) ? $past(wbuf1_r) : $past(wbuf0_r)))
      else $error("pending write not forwarded");
   echo_rise_a: assert property (o_rise |=> strobe_r && !strobe_n_r)
      else $error("echo clock not high after output edge");
   echo_fall_a: assert property (o_n_rise && !o_rise |=> !strobe_r && strobe_n_r)
      else $error("echo clock not low after complement edge");
   hold_data_a: assert property (!(o_edge && slot_v_r[0]) |=> $stable(rd_data_r))
      else $error("read data moved without a burst edge");

   slow_read_c: cover property (rd_take && pll_s ##[1:40] o_edge && slot_v_r[0]);
   fast_read_c: cover property (rd_take && !pll_s ##[1:40] o_edge && slot_v_r[0]);
   bypass_c: cover property (o_edge && slot_v_r[0] && bypass_hit);
   both_ports_c: cover property (rd_take && wr_take);
endmodule // dpb_mem
`default_nettype wire

// ---- dpb_mem_tb_top.sv ----
// Self-checking bench for the dual-port burst memory.
`timescale 1ns/10ps
`default_nettype none
module dpb_mem_tb_top;
   import dpb_pkg::*;
   localparam int DW = DPB_DATA_W;
   logic clk_i = 1'b0, rstn_i = 1'b0, single_clk = 1'b1, pll_dis = 1'b0, rd_go = 1'b0, wr_go = 1'b0;
   logic [DPB_ADDR_W-1:0] ra = '0, wa = '0, addr;
   logic [2*DW-1:0] wp = '0;
   logic [DW-1:0] last_w = '0, wd, rd_data;
   logic [2:0] ph;
   logic k, k_n, c, c_n, rsn, wsn, st, st_n;
   int failures = 0, samples_checked = 0, cycles = 0;
   // Memory under test and the controller on its pins.
   dpb_mem i_dpb_mem (.clk_i(clk_i), .rstn_i(rstn_i), .link_k_i(k), .link_k_n_i(k_n), .out_c_i(c),
      .out_c_n_i(c_n), .single_clk_i(single_clk), .pll_disable_i(pll_dis), .addr_i(addr),
      .rd_sel_n_i(rsn), .wr_sel_n_i(wsn), .wr_data_i(wd), .rd_data_o(rd_data),
      .returned_timing_strobe_o(st), .returned_timing_strobe_n_o(st_n));
   dpb_ctl_model i_dpb_ctl_model (.clk_i(clk_i), .rstn_i(rstn_i), .rd_go_i(rd_go), .wr_go_i(wr_go),
      .ra_i(ra), .wa_i(wa), .wp_i(wp), .ph_o(ph), .k_o(k), .k_n_o(k_n), .c_o(c), .c_n_o(c_n),
      .addr_o(addr), .rd_sel_n_o(rsn), .wr_sel_n_o(wsn), .wd_o(wd));
   // System clock, 20 ns period.
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   // Cut a hang short; the full run needs well under a thousand clocks.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         final_report();
      end
   end
   // Compare one read word.
   task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
      end
   endtask
   // Compare one echo strobe level.
   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t strobe %b expected %b", $time, got, exp);
      end
   endtask
   // One K cycle of requests; with chk set, both burst words and strobes are judged.
   // A read port left unselected must leave the read output holding its last word.
   task automatic xfer(input logic rg, input logic wg, input logic [DPB_ADDR_W-1:0] a_r,
         input logic [DPB_ADDR_W-1:0] a_w, input logic [2*DW-1:0] pair, input logic [2*DW-1:0] exp,
         input logic chk);
      int off;
      off = (single_clk ? 0 : 2) + (pll_dis ? 12 : 8);
      do @(negedge clk_i); while (ph !== 3'h5);
      @(posedge clk_i);
      rd_go <= rg;
      wr_go <= wg;
      ra <= a_r;
      wa <= a_w;
      wp <= pair;
      @(posedge clk_i);
      rd_go <= 1'b0;
      wr_go <= 1'b0;
      if (chk) begin
         repeat (off + 8) @(posedge clk_i);
         @(negedge clk_i);
         chk_word(rd_data, rg ? exp[DW-1:0] : last_w);
         chk_bit(st, !pll_dis);
         chk_bit(st_n, pll_dis);
         repeat (4) @(posedge clk_i);
         @(negedge clk_i);
         if (rg) last_w = exp[2*DW-1:DW];
         chk_word(rd_data, last_w);
         chk_bit(st, pll_dis);
         chk_bit(st_n, !pll_dis);
      end
   endtask
   // Each latency and output clock source: write a pair, then read it back.
   task automatic s_modes();
      logic [2*DW-1:0] p;
      for (int m = 0; m < 4; m++) begin
         p = 36'h5_A3C1_E0F0 + 36'(m);
         @(posedge clk_i);
         single_clk <= m[1];
         pll_dis <= m[0];
         repeat (16) @(posedge clk_i);
         xfer(1'b0, 1'b1, '0, DPB_ADDR_W'(m + 4), p, '0, 1'b1);
         xfer(1'b1, 1'b0, DPB_ADDR_W'(m + 4), '0, '0, p, 1'b1);
      end
   endtask
   // Read and write taken at the same K rise, top address on the write side.
   task automatic s_concur();
      xfer(1'b1, 1'b1, 19'h0_0007, 19'h7_FFFF, 36'hF_0123_4567, 36'h5_A3C1_E0F3, 1'b1);
      xfer(1'b1, 1'b0, 19'h7_FFFF, '0, '0, 36'hF_0123_4567, 1'b1);
   endtask
   // Two writes back to back to one address, the second beside a read of it, then a read.
   task automatic s_newest();
      xfer(1'b0, 1'b1, '0, 19'h0_0100, 36'h9_9999_6666, '0, 1'b0);
      xfer(1'b1, 1'b1, 19'h0_0100, 19'h0_0100, 36'h3_C3C3_1E1E, 36'h3_C3C3_1E1E, 1'b1);
      xfer(1'b1, 1'b0, 19'h0_0100, '0, '0, 36'h3_C3C3_1E1E, 1'b1);
   endtask
   // Both selects high with live address and data: nothing may change.
   task automatic s_desel();
      xfer(1'b0, 1'b0, 19'h0_0100, 19'h0_0100, 36'h0_0F0F_00FF, '0, 1'b1);
      xfer(1'b1, 1'b0, 19'h0_0100, '0, '0, 36'h3_C3C3_1E1E, 1'b1);
   endtask
   // Print the counts and the verdict, then stop.
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Reset for eight clocks, then the scenarios in turn.
   initial begin
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      s_modes();
      s_concur();
      s_newest();
      s_desel();
      final_report();
   end
endmodule // dpb_mem_tb_top
`default_nettype wire

// ---- dpb_pkg.sv ----
// Constants and types shared by the dual-port burst memory, its controller model and its bench.
`default_nettype none
package dpb_pkg;
   // Word width per configuration and address width of the array.
   localparam int DPB_DATA_W = 18;
   localparam int DPB_ADDR_W = 19;
   // Read scheduling: slots counted in upcoming output clock edges.
   localparam int DPB_RD_SLOTS = 4;
   localparam int DPB_LAT_ONE_IDX = 1;
   localparam int DPB_LAT_HALF_IDX = 2;
   // Count of single-bit pins passed through the input synchroniser.
   localparam int DPB_CTRL_PINS = 8;
   // Write sequencing states.
   typedef enum logic [2:0] {
      DPB_WR_IDLE   = 3'h1,
      DPB_WR_HALF   = 3'h2,
      DPB_WR_COMMIT = 3'h4
   } dpb_wr_state_t;
endpackage
`default_nettype wire
